// file: dbr_pkg.sv
// Package with the constants, types and decode function of the bank block.
package dbr_pkg;
  localparam int DBR_BANKS = 8;
  localparam int DBR_ROW_W = 15;
  localparam int DBR_COL_W = 10;
  localparam int DBR_CNT_W = 8;
  localparam int DBR_AP_BIT = 10;
  localparam int DBR_CHOP_BIT = 12;
  // Write data beats occupy one clock per pair of beats.
  localparam logic [7:0] DBR_BL8_CK = 8'h04;
  localparam logic [7:0] DBR_BC4_CK = 8'h02;
  // Register byte offsets.
  localparam logic [11:0] DBR_OFS_MODE = 12'h000;
  localparam logic [11:0] DBR_OFS_TIMING = 12'h004;
  localparam logic [11:0] DBR_OFS_BANKS = 12'h008;
  localparam logic [11:0] DBR_OFS_ERR = 12'h00C;
  localparam logic [11:0] DBR_OFS_LAST = 12'h010;
  // Field positions.
  localparam int DBR_TIM_TRP_LSB = 0;
  localparam int DBR_TIM_MINIMUM_ROW_ACTIVE_TIME_LSB = 8;
  localparam int DBR_TIM_WRD_LSB = 16;
  localparam int DBR_ERR_OPEN = 0;
  localparam int DBR_ERR_EARLY = 1;
  localparam int DBR_ERR_IDLE = 2;
  // Reset values.
  localparam logic [1:0] DBR_MODE_RST = 2'h0;
  localparam logic [7:0] DBR_TRP_RST = 8'h10;
  localparam logic [7:0] DBR_MINIMUM_ROW_ACTIVE_TIME_RST = 8'h20;
  localparam logic [7:0] DBR_WRD_RST = 8'h18;
  // Burst length field encodings.
  localparam logic [1:0] DBR_BL_FIXED8 = 2'h0;
  localparam logic [1:0] DBR_BL_OTF = 2'h1;
  localparam logic [1:0] DBR_BL_FIXED4 = 2'h2;

  typedef enum logic [2:0]
  {
    DBR_CMD_NOP = 3'b000,
    DBR_CMD_ACT = 3'b001,
    DBR_CMD_PRE = 3'b010,
    DBR_CMD_PREA = 3'b011,
    DBR_CMD_RD = 3'b100,
    DBR_CMD_WR = 3'b101
  } dbr_cmd_t;

  typedef enum logic [1:0]
  {
    DBR_BK_IDLE = 2'b00,
    DBR_BK_ACTIVE = 2'b01,
    DBR_BK_AUTOPRE = 2'b10,
    DBR_BK_PRECHG = 2'b11
  } dbr_bank_t;

  // Flat bank number from bank group and bank within the group.
  function automatic logic [2:0] dbr_bank_index(input logic bg,
                                                input logic [1:0] ba);
    dbr_bank_index = {bg, ba};
  endfunction
endpackage

// file: dbr_bank_if.sv
// Interface carrying one bank's command strobes and its state back.
`timescale 1ns/1ps
interface dbr_bank_if;
  import dbr_pkg::*;
  logic act;
  logic pre;
  logic access;
  logic is_write;
  logic auto_pre;
  logic burst_eight;
  logic [DBR_ROW_W-1:0] row_in;
  dbr_bank_t state;
  logic [DBR_ROW_W-1:0] open_row;
  modport ctrl (output act, pre, access, is_write, auto_pre, burst_eight,
                row_in, input state, open_row);
  modport bank (input act, pre, access, is_write, auto_pre, burst_eight,
                row_in, output state, open_row);
endinterface

// file: dbr_burst.sv
// Burst length decode from the mode field and the chop address bit.
`timescale 1ns/1ps
module dbr_burst
(
  // Mode and command.
  input wire logic [1:0] bl_field,
  input wire logic chop_bit,
  // Result.
  output logic burst_eight
);
  import dbr_pkg::*;

  // Field 11 is reserved and falls back to eight beats.
  always_comb
  begin
    case (bl_field)
      DBR_BL_FIXED8: burst_eight = 1'b1;
      DBR_BL_OTF: burst_eight = chop_bit;
      DBR_BL_FIXED4: burst_eight = 1'b0;
      default: burst_eight = 1'b1;
    endcase
  end
endmodule

// file: dbr_bank.sv
// One bank: open row, precharge timing and the auto precharge lockout.
`timescale 1ns/1ps
module dbr_bank
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Timing settings in clocks.
  input wire logic [dbr_pkg::DBR_CNT_W-1:0] precharge_period,
  input wire logic [dbr_pkg::DBR_CNT_W-1:0] minimum_row_active_time,
  input wire logic [dbr_pkg::DBR_CNT_W-1:0] wrd,
  // Commands and state.
  dbr_bank_if.bank bif
);
  import dbr_pkg::*;

  dbr_bank_t state;
  logic [DBR_CNT_W-1:0] pre_cnt;
  logic [DBR_CNT_W-1:0] ras_cnt;
  logic [DBR_CNT_W-1:0] ap_cnt;
  logic ap_go;
  logic start_pre;

  assign bif.state = state;
  // Reads wait only for the row active time, writes also for their data.
  assign ap_go = (ap_cnt == '0) && (ras_cnt >= minimum_row_active_time);
  // A precharge to an idle bank starts nothing and raises nothing.
  assign start_pre = (bif.pre && state != DBR_BK_IDLE) ||
                     (state == DBR_BK_AUTOPRE && ap_go);

  // Bank state machine.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= DBR_BK_IDLE;
    else
      case (state)
        DBR_BK_IDLE:
          if (bif.act)
            state <= DBR_BK_ACTIVE;
        DBR_BK_ACTIVE:
          if (bif.pre)
            state <= DBR_BK_PRECHG;
          else if (bif.access && bif.auto_pre)
            state <= DBR_BK_AUTOPRE;
        DBR_BK_AUTOPRE:
          if (start_pre)
            state <= DBR_BK_PRECHG;
        DBR_BK_PRECHG:
          if (!bif.pre && pre_cnt <= 8'h01)
            state <= DBR_BK_IDLE;
        default: state <= DBR_BK_IDLE;
      endcase
  end

  // Open row address is captured only when an idle bank is activated.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bif.open_row <= '0;
    else if (bif.act && state == DBR_BK_IDLE)
      bif.open_row <= bif.row_in;
  end

  // Precharge period counter, restarted by every later precharge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_cnt <= '0;
    else if (start_pre)
      pre_cnt <= precharge_period;
    else if (pre_cnt != '0)
      pre_cnt <= pre_cnt - 8'h01;
  end

  // Row active time counter, saturating so long rows stay satisfied.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ras_cnt <= '0;
    else if (bif.act && state == DBR_BK_IDLE)
      ras_cnt <= '0;
    else if (ras_cnt != 8'hFF)
      ras_cnt <= ras_cnt + 8'h01;
  end

  // Write recovery plus burst clocks before an auto precharge may start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ap_cnt <= '0;
    else if (state == DBR_BK_ACTIVE && bif.access && bif.auto_pre)
      ap_cnt <= bif.is_write ?
                wrd + (bif.burst_eight ? DBR_BL8_CK : DBR_BC4_CK) :
                8'h00;
    else if (ap_cnt != '0)
      ap_cnt <= ap_cnt - 8'h01;
  end

  auto_read_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == DBR_BK_AUTOPRE && ras_cnt < minimum_row_active_time && !bif.pre
    |=> state != DBR_BK_PRECHG)
    else $error("auto precharge began before row active time");
  auto_write_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == DBR_BK_AUTOPRE && ap_cnt != '0 && !bif.pre
    |=> state == DBR_BK_AUTOPRE)
    else $error("auto precharge began before write data stored");
  repeat_pre_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == DBR_BK_PRECHG && bif.pre |=> pre_cnt == $past(precharge_period))
    else $error("repeated precharge did not restart the period");
  row_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == DBR_BK_ACTIVE && !bif.pre && !bif.access
    |=> state == DBR_BK_ACTIVE && $stable(bif.open_row))
    else $error("open row lost without a precharge");
endmodule

// file: dbr_top.sv
// Bank row and burst control: pin capture, banks and the APB registers.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module dbr_top
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command and address pins from the memory controller.
  input wire logic [2:0] cmd_code,
  input wire logic bank_group_input,
  input wire logic [1:0] bank_select_inputs,
  input wire logic [dbr_pkg::DBR_ROW_W-1:0] row_address_inputs,
  // Access issued to the array.
  output logic acc_valid,
  output logic [2:0] acc_bank,
  output logic [dbr_pkg::DBR_ROW_W-1:0] acc_row,
  output logic [dbr_pkg::DBR_COL_W-1:0] acc_column,
  output logic acc_write,
  output logic acc_burst_eight,
  output logic acc_auto_pre,
  // Per-bank open flags.
  output logic [dbr_pkg::DBR_BANKS-1:0] bank_open
);
  import dbr_pkg::*;

  logic [2:0] cmd_s1;
  logic [2:0] cmd_s2;
  logic bg_s1;
  logic bg_s2;
  logic [1:0] ba_s1;
  logic [1:0] ba_s2;
  logic [DBR_ROW_W-1:0] addr_s1;
  logic [DBR_ROW_W-1:0] addr_s2;
  dbr_cmd_t cmd;
  logic [2:0] idx;
  logic burst_eight;
  logic is_act;
  logic is_access;
  logic [1:0] mode_bl;
  logic [7:0] precharge_period;
  logic [7:0] minimum_row_active_time;
  logic [7:0] wrd;
  logic [2:0] err;
  logic [2:0] err_set;
  logic [2:0] err_clr;
  dbr_bank_t bank_state [DBR_BANKS];
  logic [DBR_ROW_W-1:0] bank_row [DBR_BANKS];
  logic [15:0] state_vec;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [31:0] next_rdata;

  // The pins come from another domain and pass two flops first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_s1 <= '0;
      cmd_s2 <= '0;
      bg_s1 <= 1'b0;
      bg_s2 <= 1'b0;
      ba_s1 <= '0;
      ba_s2 <= '0;
      addr_s1 <= '0;
      addr_s2 <= '0;
    end
    else
    begin
      cmd_s1 <= cmd_code;
      cmd_s2 <= cmd_s1;
      bg_s1 <= bank_group_input;
      bg_s2 <= bg_s1;
      ba_s1 <= bank_select_inputs;
      ba_s2 <= ba_s1;
      addr_s1 <= row_address_inputs;
      addr_s2 <= addr_s1;
    end
  end

  // Command decode on the settled pins.
  assign cmd = dbr_cmd_t'(cmd_s2);
  assign idx = dbr_bank_index(bg_s2, ba_s2);
  assign is_act = (cmd == DBR_CMD_ACT);
  assign is_access = (cmd == DBR_CMD_RD) || (cmd == DBR_CMD_WR);

  dbr_burst u_burst
  (
    .bl_field(mode_bl),
    .chop_bit(addr_s2[DBR_CHOP_BIT]),
    .burst_eight(burst_eight)
  );

  // One tracker per bank; all-bank precharge reaches every one.
  genvar gi;
  generate
    for (gi = 0; gi < DBR_BANKS; gi++)
    begin : g_bank
      dbr_bank_if bif();
      assign bif.act = is_act && idx == 3'(gi);
      assign bif.pre = (cmd == DBR_CMD_PRE && idx == 3'(gi)) ||
                       cmd == DBR_CMD_PREA;
      // Auto precharge elsewhere never blocks this bank's access.
      assign bif.access = is_access && idx == 3'(gi);
      assign bif.is_write = (cmd == DBR_CMD_WR);
      assign bif.auto_pre = addr_s2[DBR_AP_BIT];
      assign bif.burst_eight = burst_eight;
      assign bif.row_in = addr_s2;
      assign bank_state[gi] = bif.state;
      assign bank_row[gi] = bif.open_row;
      assign state_vec[2*gi +: 2] = bif.state;
      dbr_bank u_bank
      (
        .pclk(pclk),
        .presetn(presetn),
        .precharge_period(precharge_period),
        .minimum_row_active_time(minimum_row_active_time),
        .wrd(wrd),
        .bif(bif)
      );
    end
  endgenerate

  // Open flags follow the bank trackers directly.
  always_comb
  begin
    for (int i = 0; i < DBR_BANKS; i++)
      bank_open[i] = (bank_state[i] == DBR_BK_ACTIVE);
  end

  // Controller misuse flags; the device itself carries on regardless.
  always_comb
  begin
    err_set = '0;
    err_set[DBR_ERR_OPEN] = is_act &&
      bank_state[idx] == DBR_BK_ACTIVE;
    err_set[DBR_ERR_EARLY] = is_act &&
      (bank_state[idx] == DBR_BK_PRECHG ||
       bank_state[idx] == DBR_BK_AUTOPRE);
    err_set[DBR_ERR_IDLE] = is_access &&
      bank_state[idx] != DBR_BK_ACTIVE;
  end

  // Accesses reach the array only on a bank that holds an open row.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_valid <= 1'b0;
      acc_bank <= '0;
      acc_row <= '0;
      acc_column <= '0;
      acc_write <= 1'b0;
      acc_burst_eight <= 1'b0;
      acc_auto_pre <= 1'b0;
    end
    else
    begin
      acc_valid <= is_access && bank_state[idx] == DBR_BK_ACTIVE;
      if (is_access)
      begin
        acc_bank <= idx;
        acc_row <= bank_row[idx];
        // Only the low column bits go on; the chop bit is excluded.
        acc_column <= addr_s2[DBR_COL_W-1:0];
        acc_write <= (cmd == DBR_CMD_WR);
        acc_burst_eight <= burst_eight;
        acc_auto_pre <= addr_s2[DBR_AP_BIT];
      end
    end
  end

  // APB decode: writes land in the access phase, reads load in setup.
  assign mapped = paddr == DBR_OFS_MODE || paddr == DBR_OFS_TIMING ||
                  paddr == DBR_OFS_BANKS || paddr == DBR_OFS_ERR ||
                  paddr == DBR_OFS_LAST;
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign err_clr = (wr_en && paddr == DBR_OFS_ERR && pstrb[0]) ?
                   pwdata[2:0] : 3'h0;

  // Mode and timing registers steer burst decode and bank counters.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_bl <= DBR_MODE_RST;
      precharge_period <= DBR_TRP_RST;
      minimum_row_active_time <= DBR_MINIMUM_ROW_ACTIVE_TIME_RST;
      wrd <= DBR_WRD_RST;
    end
    else if (wr_en)
    begin
      if (paddr == DBR_OFS_MODE && pstrb[0])
        mode_bl <= pwdata[1:0];
      if (paddr == DBR_OFS_TIMING)
      begin
        if (pstrb[0])
          precharge_period <= pwdata[DBR_TIM_TRP_LSB +: 8];
        if (pstrb[1])
          minimum_row_active_time <= pwdata[DBR_TIM_MINIMUM_ROW_ACTIVE_TIME_LSB +: 8];
        if (pstrb[2])
          wrd <= pwdata[DBR_TIM_WRD_LSB +: 8];
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle survives the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err <= '0;
    else
      err <= (err & ~err_clr) | err_set;
  end

  // Read mux; unmapped addresses read zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      DBR_OFS_MODE: next_rdata = {30'h0, mode_bl};
      DBR_OFS_TIMING: next_rdata = {8'h00, wrd, minimum_row_active_time, precharge_period};
      DBR_OFS_BANKS: next_rdata = {16'h0000, state_vec};
      DBR_OFS_ERR: next_rdata = {29'h0, err};
      DBR_OFS_LAST: next_rdata = {14'h0, acc_auto_pre, acc_burst_eight,
                                  acc_write, acc_bank, 2'h0, acc_column};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data and the error answer are registered at the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= rd_en ? next_rdata : 32'h0000_0000;
      pslverr <= !mapped;
    end
  end

  sequence act_idle_s;
    is_act && bank_state[idx] == DBR_BK_IDLE;
  endsequence
  sequence pre_open_s;
    cmd == DBR_CMD_PRE && bank_state[idx] == DBR_BK_ACTIVE;
  endsequence

  act_opens_a: assert property (@(posedge pclk) disable iff (!presetn)
    act_idle_s |=> bank_open[$past(idx)])
    else $error("activation did not open the bank");
  pre_closes_a: assert property (@(posedge pclk) disable iff (!presetn)
    pre_open_s |=> bank_state[$past(idx)] == DBR_BK_PRECHG)
    else $error("precharge did not close the row");
  pre_idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    cmd == DBR_CMD_PRE && bank_state[idx] == DBR_BK_IDLE && !err[0]
    && !err[1] && !err[2] && err_clr == 3'h0 && !is_access && !is_act
    |=> err == 3'h0)
    else $error("precharge to an idle bank raised a flag");
  auto_pre_ends_a: assert property (@(posedge pclk) disable iff (!presetn)
    is_access && addr_s2[DBR_AP_BIT] &&
    bank_state[idx] == DBR_BK_ACTIVE
    ##1 cmd == DBR_CMD_NOP [*8]
    |-> ##[1:600] bank_state[acc_bank] == DBR_BK_IDLE)
    else $error("auto precharge never returned the bank to idle");
  fixed_four_a: assert property (@(posedge pclk) disable iff (!presetn)
    is_access && mode_bl == DBR_BL_FIXED4 |=> !acc_burst_eight)
    else $error("fixed chop mode gave eight beats");
  otf_chop_a: assert property (@(posedge pclk) disable iff (!presetn)
    is_access && mode_bl == DBR_BL_OTF
    |=> acc_burst_eight == $past(addr_s2[DBR_CHOP_BIT]))
    else $error("on the fly burst length mismatch");
  fixed_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
    is_access && mode_bl == DBR_BL_FIXED8 |=> acc_burst_eight)
    else $error("field 00 did not give eight beats");
  column_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
    is_access |=> acc_column == $past(addr_s2[DBR_COL_W-1:0]))
    else $error("column address corrupted");
  idle_access_flag_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    is_access && bank_state[idx] == DBR_BK_IDLE
    |=> err[DBR_ERR_IDLE] && !acc_valid)
    else $error("access to idle bank not flagged");
endmodule

// file: dbr_ctl_model.sv
// Memory controller model that drives the command and address pins.
`timescale 1ns/1ps
module dbr_ctl_model
#(
  parameter int TRP_CLK = 24,
  parameter int AP_CLK = 90
)
(
  // Clock.
  input wire logic pclk,
  // Command and address pins.
  output logic [2:0] cmd_code,
  output logic bank_group_input,
  output logic [1:0] bank_select_inputs,
  output logic [dbr_pkg::DBR_ROW_W-1:0] row_address_inputs
);
  import dbr_pkg::*;
  int now_cyc = 0;
  int free_at [DBR_BANKS];

  // A free-running count lets the model space its row activations.
  always @(posedge pclk)
    now_cyc <= now_cyc + 1;

  // Pins start at no operation with every bank free.
  initial
  begin
    cmd_code = DBR_CMD_NOP;
    bank_group_input = 1'b0;
    bank_select_inputs = 2'h0;
    row_address_inputs = '0;
    foreach (free_at[i])
      free_at[i] = 0;
  end

  // One command for one clock, then no operation; the address lines flip
  // so that a stale value is never mistaken for a held one.
  task automatic issue(input logic [2:0] c, input logic [2:0] b,
                       input logic [DBR_ROW_W-1:0] a, input bit gate);
    while (gate && c == DBR_CMD_ACT && now_cyc < free_at[b])
      @(posedge pclk);
    cmd_code <= c;
    {bank_group_input, bank_select_inputs} <= b;
    row_address_inputs <= a;
    @(posedge pclk);
    cmd_code <= DBR_CMD_NOP;
    row_address_inputs <= ~a;
    if (c == DBR_CMD_PRE)
      free_at[b] = now_cyc + TRP_CLK;
    if (c == DBR_CMD_PREA)
      foreach (free_at[i])
        free_at[i] = now_cyc + TRP_CLK;
    if (c >= DBR_CMD_RD && a[DBR_AP_BIT])
      free_at[b] = now_cyc + AP_CLK;
  endtask
endmodule

// file: dbr_bank_row_and_burst_control_bench.sv
// Self-checking bench for the bank row and burst control block.
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("BAD %0t got %0h exp %0h", $time, g, e); \
    end \
  end
module dbr_bank_row_and_burst_control_bench;
  import dbr_pkg::*;
  localparam int PRECHARGE_PERIOD = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0] pstrb;
  logic [2:0] cmd_code, acc_bank, b;
  logic bank_group_input, acc_valid, acc_write, acc_burst_eight;
  logic acc_auto_pre;
  logic [1:0] bank_select_inputs;
  logic [14:0] row_address_inputs, acc_row;
  logic [9:0] acc_column;
  logic [7:0] bank_open;
  int miscompares = 0;
  int n_compared = 0;
  int m_open [8];
  logic [14:0] m_row [8];
  int m_mode = 0;
  logic [31:0] seed = 32'h0000002C;

  dbr_top u_dbr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .cmd_code,
    .bank_group_input, .bank_select_inputs, .row_address_inputs,
    .acc_valid, .acc_bank, .acc_row, .acc_column, .acc_write,
    .acc_burst_eight, .acc_auto_pre, .bank_open);
  dbr_ctl_model #(.TRP_CLK(PRECHARGE_PERIOD + 4), .AP_CLK(90)) u_dbr_ctl_model (.pclk,
    .cmd_code, .bank_group_input, .bank_select_inputs, .row_address_inputs);

  // Clock of 4 ns.
  initial
    pclk = 1'b0;
  always #2 pclk = ~pclk;

  // Xorshift keeps the run repeatable from one fixed seed.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One APB transfer, held until pready is seen high at a rising edge.
  // An edge passes first, so a release and the next setup never share a
  // time step.
  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Issues a command, steps the bank model and checks the outputs two
  // edges after the issue returns, while the access pulse still stands.
  task automatic cmd(input dbr_cmd_t c, input logic [2:0] bk,
                     input logic [14:0] a, input bit gate);
    logic [7:0] ev;
    int was;
    was = m_open[bk];
    u_dbr_ctl_model.issue(c, bk, a, gate);
    if (c == DBR_CMD_ACT && gate && was == 0)
    begin
      m_open[bk] = 1;
      m_row[bk] = a;
    end
    if (c == DBR_CMD_PRE || (c >= DBR_CMD_RD && a[DBR_AP_BIT]))
      m_open[bk] = 0;
    if (c == DBR_CMD_PREA)
      foreach (m_open[i])
        m_open[i] = 0;
    repeat (2) @(posedge pclk);
    #1;
    foreach (m_open[i])
      ev[i] = (m_open[i] != 0);
    `CHK(bank_open, ev);
    if (c >= DBR_CMD_RD)
    begin
      `CHK(acc_valid, 1'(was != 0));
      if (was != 0)
      begin
        `CHK(acc_bank, bk);
        `CHK(acc_row, m_row[bk]);
        `CHK(acc_column, a[9:0]);
        `CHK(acc_write, 1'(c == DBR_CMD_WR));
        `CHK(acc_burst_eight, m_mode == 2 ? 1'b0 : (m_mode == 1 ?
          a[DBR_CHOP_BIT] : 1'b1));
        `CHK(acc_auto_pre, a[DBR_AP_BIT]);
      end
    end
    @(posedge pclk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang is cut short well past the expected length of the run.
  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    $display("BAD %0t timeout", $time);
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    foreach (m_open[i])
      m_open[i] = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, DBR_OFS_TIMING, 32'h0);
    `CHK(rd, 32'h00182010);
    apb(0, 12'h014, 32'h0);
    `CHK(er, 1'b1);
    apb(1, DBR_OFS_TIMING, {8'h00, 8'h18, 8'h20, 8'(PRECHARGE_PERIOD)});
    $display("test registers done");
    // Two rows open at once; every burst mode and both chop levels.
    for (int md = 0; md < 4; md++)
    begin
      m_mode = md;
      apb(1, DBR_OFS_MODE, 32'(md));
      r = rnd();
      b = r[2:0];
      cmd(DBR_CMD_ACT, b, r[30:16], 1);
      cmd(DBR_CMD_ACT, b ^ 3'h4, r[24:10], 1);
      for (int k = 0; k < 4; k++)
      begin
        r = rnd();
        cmd(k[0] ? DBR_CMD_WR : DBR_CMD_RD, b,
            {r[14:13], k[1], r[11], 1'b0, r[9:0]}, 1);
      end
      cmd(DBR_CMD_PREA, 3'h0, 15'h0000, 1);
    end
    $display("test bursts done");
    // Let the all-bank precharge run out so that bank 2 is truly idle.
    repeat (PRECHARGE_PERIOD + 4) @(posedge pclk);
    cmd(DBR_CMD_RD, 3'h2, 15'h0000, 1);
    apb(0, DBR_OFS_ERR, 32'h0);
    `CHK(rd[DBR_ERR_IDLE], 1'b1);
    apb(1, DBR_OFS_ERR, 32'h7);
    cmd(DBR_CMD_PRE, 3'h2, 15'h0000, 1);
    apb(0, DBR_OFS_ERR, 32'h0);
    `CHK(rd, 32'h0);
    $display("test idle bank done");
    // Second precharge restarts the period; an early activation is refused.
    cmd(DBR_CMD_ACT, 3'h3, 15'h1234, 1);
    cmd(DBR_CMD_PRE, 3'h3, 15'h0000, 1);
    repeat (10) @(posedge pclk);
    cmd(DBR_CMD_PRE, 3'h3, 15'h0000, 1);
    repeat (5) @(posedge pclk);
    cmd(DBR_CMD_ACT, 3'h3, 15'h4321, 0);
    apb(0, DBR_OFS_ERR, 32'h0);
    `CHK(rd[DBR_ERR_EARLY], 1'b1);
    cmd(DBR_CMD_ACT, 3'h3, 15'h4321, 1);
    $display("test repeated precharge done");
    // Read with auto precharge waits out the row active time.
    cmd(DBR_CMD_ACT, 3'h1, 15'h0AAA, 1);
    cmd(DBR_CMD_ACT, 3'h5, 15'h7555, 1);
    cmd(DBR_CMD_RD, 3'h5, 15'h1400, 1);
    apb(0, DBR_OFS_BANKS, 32'h0);
    `CHK(rd[11:10], 2'h2);
    cmd(DBR_CMD_RD, 3'h1, 15'h0055, 1);
    repeat (70) @(posedge pclk);
    apb(0, DBR_OFS_BANKS, 32'h0);
    `CHK(rd[11:10], 2'h0);
    cmd(DBR_CMD_ACT, 3'h5, 15'h0101, 1);
    $display("test read auto precharge done");
    // Write with auto precharge holds until its last data is stored.
    cmd(DBR_CMD_ACT, 3'h6, 15'h3C3C, 1);
    repeat (40) @(posedge pclk);
    cmd(DBR_CMD_WR, 3'h6, 15'h1433, 1);
    apb(0, DBR_OFS_BANKS, 32'h0);
    `CHK(rd[13:12], 2'h2);
    repeat (80) @(posedge pclk);
    apb(0, DBR_OFS_BANKS, 32'h0);
    `CHK(rd[13:12], 2'h0);
    $display("test write auto precharge done");
    report_and_stop();
  end
endmodule
